// file: hrp_dev.sv
// Device end: byte FIFO, blank check, password check and record parser.
`timescale 1ns/1ns
module hrp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;
  assign in_ready = !((wp_q[AW] != rp_q[AW]) &&
                      (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data = mem[rp_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // hrp_fifo

module hrp_dev (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  hrp_link_if.dev LNK,
  input wire logic [1:0] MODE,
  input wire logic RX_ERROR,
  output logic [15:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_DATA,
  output logic REC_WR,
  output logic [15:0] REC_ADDR,
  output logic [15:0] REC_EXT,
  output logic [7:0] REC_DATA,
  output logic BLANK,
  output logic HALTED,
  output logic DONE
);
  hrp_pkg::hrp_dst_t st_q;
  logic f_valid;
  logic [7:0] f_data;
  logic f_ready;
  logic take;
  logic ph_q;
  logic [15:0] fa_q;
  logic blank_q;
  logic [2:0] hcnt_q;
  logic [31:0] hdr_q;
  logic [7:0] n_q;
  logic [7:0] idx_q;
  logic [7:0] prev_q;
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [7:0] sum_q;
  logic [7:0] len_q;
  logic [7:0] type_q;
  logic [15:0] addr_q;
  logic [15:0] ext_q;
  logic [15:0] ext_acc_q;
  logic ext_hi_q;
  logic [15:0] tot_q;
  logic [7:0] tx_q;
  logic txv_q;
  logic [15:0] password_count_address;
  logic [15:0] password_compare_start;
  logic last_byte;

  hrp_fifo #(.W(hrp_pkg::BYTE_W), .DEPTH(hrp_pkg::FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .in_valid(LNK.h2d_valid),
    .in_data(LNK.h2d_data),
    .in_ready(LNK.h2d_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  assign password_count_address = hdr_q[31:16];
  assign password_compare_start = hdr_q[15:0];
  assign last_byte = (idx_q + 8'h01 == n_q);
  assign f_ready = (st_q == hrp_pkg::S_HDR) || (st_q == hrp_pkg::S_PWCMP) ||
                   (st_q == hrp_pkg::S_WAITMK) || (st_q == hrp_pkg::S_LEN) ||
                   (st_q == hrp_pkg::S_AH) || (st_q == hrp_pkg::S_AL) ||
                   (st_q == hrp_pkg::S_TYPE) || (st_q == hrp_pkg::S_DATA) ||
                   (st_q == hrp_pkg::S_CSUM);
  assign take = f_valid && f_ready;
  assign FLASH_ADDR = fa_q;
  assign BLANK = blank_q;
  assign HALTED = (st_q == hrp_pkg::S_HALT);
  assign DONE = (st_q == hrp_pkg::S_DONE);
  assign REC_EXT = ext_q;
  assign LNK.d2h_valid = txv_q;
  assign LNK.d2h_data = tx_q;
  assign run_d = ((idx_q != 8'h00) && (FLASH_DATA == prev_q)) ?
                 run_q + 2'h1 : 2'h1;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q <= hrp_pkg::S_BLANK;
      ph_q <= 1'b0;
      fa_q <= hrp_pkg::BLANK_LO;
      blank_q <= 1'b1;
      hcnt_q <= 3'h0;
      hdr_q <= 32'h0;
      n_q <= 8'h00;
      idx_q <= 8'h00;
      prev_q <= 8'h00;
      run_q <= 2'h0;
    end else if (RX_ERROR && (st_q != hrp_pkg::S_DONE)) begin
      st_q <= hrp_pkg::S_HALT;
    end else begin
      case (st_q)
        hrp_pkg::S_BLANK: begin
          ph_q <= !ph_q;
          if (ph_q) begin
            if (FLASH_DATA != hrp_pkg::ERASED) begin
              blank_q <= 1'b0;
            end
            if (fa_q == hrp_pkg::BLANK_HI) begin
              st_q <= hrp_pkg::S_HDR;
            end else begin
              fa_q <= fa_q + 16'h0001;
            end
          end
        end
        hrp_pkg::S_HDR: begin
          if (take) begin
            hdr_q <= {hdr_q[23:0], f_data};
            hcnt_q <= hcnt_q + 3'h1;
            if (hcnt_q + 3'h1 == hrp_pkg::HDR_BYTES) begin
              st_q <= hrp_pkg::S_CHK;
            end
          end
        end
        hrp_pkg::S_CHK: begin
          if (!hrp_pkg::pw_window(password_count_address) ||
              !hrp_pkg::pw_window(password_compare_start)) begin
            st_q <= hrp_pkg::S_HALT;
          end else if (blank_q) begin
            st_q <= (MODE == hrp_pkg::MODE_ERASE) ? hrp_pkg::S_DONE :
                    hrp_pkg::S_WAITMK;
          end else begin
            fa_q <= password_count_address;
            st_q <= hrp_pkg::S_CHK2;
          end
        end
        hrp_pkg::S_CHK2: begin
          ph_q <= !ph_q;
          if (ph_q) begin
            n_q <= FLASH_DATA;
            if ((FLASH_DATA < hrp_pkg::PW_MIN) ||
                ({1'b0, password_compare_start} + {9'h000, FLASH_DATA} >
                 hrp_pkg::PW_TOP)) begin
              st_q <= hrp_pkg::S_HALT;
            end else begin
              fa_q <= password_compare_start;
              idx_q <= 8'h00;
              st_q <= hrp_pkg::S_PWRD;
            end
          end
        end
        hrp_pkg::S_PWRD: begin
          st_q <= hrp_pkg::S_PWCMP;
        end
        hrp_pkg::S_PWCMP: begin
          if (take) begin
            prev_q <= FLASH_DATA;
            run_q <= run_d;
            idx_q <= idx_q + 8'h01;
            fa_q <= fa_q + 16'h0001;
            if ((f_data != FLASH_DATA) || (run_d >= hrp_pkg::RUN_MAX)) begin
              st_q <= hrp_pkg::S_HALT;
            end else if (last_byte) begin
              st_q <= (MODE == hrp_pkg::MODE_ERASE) ? hrp_pkg::S_DONE :
                      hrp_pkg::S_WAITMK;
            end else begin
              st_q <= hrp_pkg::S_PWRD;
            end
          end
        end
        hrp_pkg::S_WAITMK: begin
          if (take && (f_data == hrp_pkg::START_MARK)) begin
            st_q <= hrp_pkg::S_LEN;
          end
        end
        hrp_pkg::S_LEN: begin
          if (take) begin
            st_q <= hrp_pkg::S_AH;
          end
        end
        hrp_pkg::S_AH: begin
          if (take) begin
            st_q <= hrp_pkg::S_AL;
          end
        end
        hrp_pkg::S_AL: begin
          if (take) begin
            st_q <= hrp_pkg::S_TYPE;
          end
        end
        hrp_pkg::S_TYPE: begin
          if (take) begin
            idx_q <= 8'h00;
            n_q <= len_q;
            if ((f_data != hrp_pkg::TYPE_DATA) &&
                (f_data != hrp_pkg::TYPE_END) &&
                (f_data != hrp_pkg::TYPE_EXT)) begin
              st_q <= hrp_pkg::S_HALT;
            end else if ((f_data == hrp_pkg::TYPE_EXT) &&
                         (len_q != hrp_pkg::EXT_LEN)) begin
              st_q <= hrp_pkg::S_HALT;
            end else if ((f_data == hrp_pkg::TYPE_END) &&
                         (len_q != hrp_pkg::END_LEN)) begin
              st_q <= hrp_pkg::S_HALT;
            end else if ((f_data == hrp_pkg::TYPE_DATA) && ext_hi_q) begin
              st_q <= hrp_pkg::S_HALT;
            end else begin
              st_q <= (len_q == 8'h00) ? hrp_pkg::S_CSUM : hrp_pkg::S_DATA;
            end
          end
        end
        hrp_pkg::S_DATA: begin
          if (take) begin
            idx_q <= idx_q + 8'h01;
            if (last_byte) begin
              st_q <= hrp_pkg::S_CSUM;
            end
          end
        end
        hrp_pkg::S_CSUM: begin
          if (take) begin
            if (sum_q + f_data != 8'h00) begin
              st_q <= hrp_pkg::S_HALT;
            end else if (type_q == hrp_pkg::TYPE_END) begin
              st_q <= hrp_pkg::S_TX;
            end else begin
              st_q <= hrp_pkg::S_WAITMK;
            end
          end
        end
        hrp_pkg::S_TX: begin
          st_q <= hrp_pkg::S_DONE;
        end
        hrp_pkg::S_DONE: begin
          st_q <= hrp_pkg::S_DONE;
        end
        hrp_pkg::S_HALT: begin
          st_q <= hrp_pkg::S_HALT;
        end
        default: begin
          st_q <= hrp_pkg::S_HALT;
        end
      endcase
    end
  end

  // Record fields, running sums and extended address.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sum_q <= 8'h00;
      len_q <= 8'h00;
      type_q <= 8'h00;
      addr_q <= 16'h0000;
      ext_q <= 16'h0000;
      ext_acc_q <= 16'h0000;
      ext_hi_q <= 1'b0;
      tot_q <= 16'h0000;
    end else if (take) begin
      sum_q <= (st_q == hrp_pkg::S_WAITMK) ? 8'h00 :
               sum_q + f_data;
      if (st_q == hrp_pkg::S_LEN) begin
        len_q <= f_data;
      end
      if (st_q == hrp_pkg::S_AH) begin
        addr_q[15:8] <= f_data;
      end
      if (st_q == hrp_pkg::S_AL) begin
        addr_q[7:0] <= f_data;
      end
      if (st_q == hrp_pkg::S_TYPE) begin
        type_q <= f_data;
      end
      if (st_q == hrp_pkg::S_DATA) begin
        if (type_q == hrp_pkg::TYPE_EXT) begin
          ext_acc_q <= {ext_acc_q[7:0], f_data};
        end else begin
          tot_q <= tot_q + {8'h00, f_data};
        end
      end
      if ((st_q == hrp_pkg::S_CSUM) && (type_q == hrp_pkg::TYPE_EXT) &&
          (sum_q + f_data == 8'h00)) begin
        ext_q <= ext_acc_q;
        ext_hi_q <= (ext_acc_q >= hrp_pkg::EXT_LIMIT);
      end
    end
  end

  // Record data strobe and checksum reply bytes.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REC_WR <= 1'b0;
      REC_ADDR <= 16'h0000;
      REC_DATA <= 8'h00;
      txv_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      REC_WR <= take && (st_q == hrp_pkg::S_DATA) &&
                (type_q == hrp_pkg::TYPE_DATA);
      if (take && (st_q == hrp_pkg::S_DATA)) begin
        REC_ADDR <= addr_q + {8'h00, idx_q};
        REC_DATA <= f_data;
      end
      txv_q <= 1'b0;
      if (take && (st_q == hrp_pkg::S_CSUM) && (type_q == hrp_pkg::TYPE_END) &&
          (sum_q + f_data == 8'h00)) begin
        txv_q <= 1'b1;
        tx_q <= tot_q[15:8];
      end else if (st_q == hrp_pkg::S_TX) begin
        txv_q <= 1'b1;
        tx_q <= tot_q[7:0];
      end
    end
  end
endmodule // hrp_dev

// file: hrp_pkg.sv
// Shared constants, state encodings and helpers of the hex record loader.
package hrp_pkg;
  localparam logic [7:0] START_MARK = 8'h3a;
  localparam logic [7:0] TYPE_DATA = 8'h00;
  localparam logic [7:0] TYPE_END = 8'h01;
  localparam logic [7:0] TYPE_EXT = 8'h02;
  localparam logic [7:0] EXT_LEN = 8'h02;
  localparam logic [7:0] END_LEN = 8'h00;
  localparam logic [15:0] EXT_LIMIT = 16'h1000;
  localparam logic [7:0] PW_MIN = 8'h08;
  localparam logic [15:0] PW_LO = 16'h1000;
  localparam logic [15:0] PW_HI = 16'hff9f;
  localparam logic [16:0] PW_TOP = 17'h0ffa0;
  localparam logic [15:0] BLANK_LO = 16'hffe0;
  localparam logic [15:0] BLANK_HI = 16'hffff;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [1:0] RUN_MAX = 2'h3;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_RAM = 2'h1;
  localparam logic [1:0] MODE_ERASE = 2'h2;
  localparam logic [2:0] HDR_BYTES = 3'h4;

  typedef enum logic [15:0] {
    S_BLANK = 16'h0001,
    S_HDR = 16'h0002,
    S_CHK = 16'h0004,
    S_PWRD = 16'h0008,
    S_PWCMP = 16'h0010,
    S_WAITMK = 16'h0020,
    S_LEN = 16'h0040,
    S_AH = 16'h0080,
    S_AL = 16'h0100,
    S_TYPE = 16'h0200,
    S_DATA = 16'h0400,
    S_CSUM = 16'h0800,
    S_TX = 16'h1000,
    S_DONE = 16'h2000,
    S_HALT = 16'h4000,
    S_CHK2 = 16'h8000
  } hrp_dst_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_HDR = 4'h2,
    C_STRM = 4'h4,
    C_WAIT = 4'h8
  } hrp_cst_t;

  // Tells whether an address lies inside the password window.
  function automatic logic pw_window(input logic [15:0] a);
    pw_window = (a >= PW_LO) && (a <= PW_HI);
  endfunction
endpackage

// file: hrp_link_if.sv
// Byte link between the programming controller and the device.
`timescale 1ns/1ns
interface hrp_link_if;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic h2d_ready;
  logic d2h_valid;
  logic [7:0] d2h_data;
  modport dev (input h2d_valid, input h2d_data, output h2d_ready,
               output d2h_valid, output d2h_data);
  modport ctl (output h2d_valid, output h2d_data, input h2d_ready,
               input d2h_valid, input d2h_data);
endinterface

// file: hrp_ctl.sv
// Controller end: sends the address header, forwards the stream (dropping password bytes for a blank device), awaits reply except in erase mode.
`timescale 1ns/1ns
module hrp_ctl (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  hrp_link_if.ctl LNK,
  input wire logic START,
  input wire logic [1:0] MODE,
  input wire logic BLANK_DEV,
  input wire logic [15:0] PASSWORD_COUNT_ADDRESS,
  input wire logic [15:0] PASSWORD_COMPARE_START,
  input wire logic USR_VALID,
  input wire logic [7:0] USR_DATA,
  input wire logic USR_PW,
  input wire logic USR_LAST,
  output logic USR_READY,
  output logic [15:0] CSUM,
  output logic CSUM_VALID,
  output logic ARG_BAD,
  output logic BUSY
);
  hrp_pkg::hrp_cst_t st_q;
  logic [31:0] sh_q;
  logic [2:0] cnt_q;
  logic drop;
  logic acc;
  logic rx_first_q;

  assign drop = USR_PW && BLANK_DEV;
  assign USR_READY = (st_q == hrp_pkg::C_STRM) && (drop || LNK.h2d_ready);
  assign acc = USR_VALID && USR_READY;
  assign LNK.h2d_valid = (st_q == hrp_pkg::C_HDR) ||
                         ((st_q == hrp_pkg::C_STRM) && USR_VALID && !drop);
  assign LNK.h2d_data = (st_q == hrp_pkg::C_HDR) ? sh_q[31:24] : USR_DATA;
  assign BUSY = (st_q != hrp_pkg::C_IDLE);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q <= hrp_pkg::C_IDLE;
      sh_q <= 32'h0;
      cnt_q <= 3'h0;
      ARG_BAD <= 1'b0;
      CSUM <= 16'h0000;
      CSUM_VALID <= 1'b0;
      rx_first_q <= 1'b0;
    end else begin
      CSUM_VALID <= 1'b0;
      case (st_q)
        hrp_pkg::C_IDLE: begin
          if (START) begin
            if (hrp_pkg::pw_window(PASSWORD_COUNT_ADDRESS) &&
                hrp_pkg::pw_window(PASSWORD_COMPARE_START)) begin
              ARG_BAD <= 1'b0;
              sh_q <= {PASSWORD_COUNT_ADDRESS,
                       PASSWORD_COMPARE_START};
              cnt_q <= 3'h0;
              st_q <= hrp_pkg::C_HDR;
            end else begin
              ARG_BAD <= 1'b1;
            end
          end
        end
        hrp_pkg::C_HDR: begin
          if (LNK.h2d_ready) begin
            sh_q <= {sh_q[23:0], 8'h00};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q + 3'h1 == hrp_pkg::HDR_BYTES) begin
              st_q <= hrp_pkg::C_STRM;
            end
          end
        end
        hrp_pkg::C_STRM: begin
          if (acc && USR_LAST) begin
            rx_first_q <= 1'b1;
            st_q <= (MODE == hrp_pkg::MODE_ERASE) ? hrp_pkg::C_IDLE :
                    hrp_pkg::C_WAIT;
          end
        end
        hrp_pkg::C_WAIT: begin
          if (LNK.d2h_valid) begin
            rx_first_q <= 1'b0;
            if (rx_first_q) begin
              CSUM[15:8] <= LNK.d2h_data;
            end else begin
              CSUM[7:0] <= LNK.d2h_data;
              CSUM_VALID <= 1'b1;
              st_q <= hrp_pkg::C_IDLE;
            end
          end
        end
        default: begin
          st_q <= hrp_pkg::C_IDLE;
        end
      endcase
    end
  end
endmodule // hrp_ctl

// file: hrp_link_asserts.sv
// Assertions on the byte link and status of the hex record loader.
`timescale 1ns/1ns
module hrp_link_asserts (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_ready,
  input wire logic d2h_valid,
  input wire logic RX_ERROR,
  input wire logic BLANK,
  input wire logic HALTED,
  input wire logic DONE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  AST_REPLY_PAIR: assert property (
    $rose(d2h_valid) |=> d2h_valid ##1 !d2h_valid)
    else $error("reply is not exactly two bytes");
  AST_DONE_AFTER_REPLY: assert property (
    $fell(d2h_valid) |-> DONE)
    else $error("reply ended without done");
  AST_DONE_HOLD: assert property (DONE |=> DONE)
    else $error("done dropped");
  AST_HALT_SILENT: assert property (HALTED |-> !d2h_valid)
    else $error("reply byte sent while halted");
  AST_HALT_HOLD: assert property (HALTED |=> HALTED)
    else $error("halt left without reset");
  AST_RX_ERR_HALT: assert property (
    RX_ERROR && !DONE |=> ##[0:2] HALTED)
    else $error("receive error did not halt");
  AST_STOP_EXCL: assert property (!(HALTED && DONE))
    else $error("halt and done together");
  AST_RESET_STATE: assert property (
    $fell(SYS_RST) |-> BLANK && !HALTED && !DONE && h2d_ready && !d2h_valid)
    else $error("wrong state after reset");
  AST_H2D_HOLD: assert property (
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("link byte changed while refused");

  cover property ($rose(d2h_valid));
  cover property ($rose(HALTED));
  cover property ($rose(DONE));
  cover property (h2d_valid && !h2d_ready);
endmodule // hrp_link_asserts

// file: testbench.sv
// Self-checking bench joining controller and device ends of the loader.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [7:0] len;
    logic [15:0] adr;
    logic [7:0] typ;
    logic [15:0] d;
    logic [7:0] cadj;
    logic hlt;
    logic [15:0] sum;
  } hrp_row_t;
  logic sys_clk, sys_rst, start, blank_dev, usr_valid, usr_pw, usr_last;
  logic usr_ready, csum_valid, arg_bad, busy, rx_error, rec_wr;
  logic blank, halted, done, took;
  logic [1:0] mode;
  logic [7:0] usr_data, flash_data, rec_data, last_dat;
  logic [15:0] cnt_adr, cmp_adr, csum, flash_addr, rec_addr, rec_ext;
  logic [15:0] csum_seen, last_adr;
  logic [7:0] mem [0:65535];
  logic [7:0] reply_q[$];
  logic [9:0] strm[$];
  int err_count, compares, cycles, wr_count;
  hrp_row_t rows [0:6] = '{
    '{8'h02, 16'h0010, 8'h00, 16'haabb, 8'h00, 1'b0, 16'h01ba},
    '{8'h00, 16'h0000, 8'h03, 16'h0000, 8'h00, 1'b1, 16'h0000},
    '{8'h01, 16'h0020, 8'h00, 16'h1100, 8'h01, 1'b1, 16'h0000},
    '{8'h01, 16'h0000, 8'h02, 16'h0000, 8'h00, 1'b1, 16'h0000},
    '{8'h02, 16'h0000, 8'h02, 16'h1000, 8'h00, 1'b1, 16'h0000},
    '{8'h02, 16'h0000, 8'h02, 16'h0fff, 8'h00, 1'b0, 16'h0055},
    '{8'h01, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b1, 16'h0000}};

  hrp_link_if lnk ();
  hrp_ctl hrp_ctl_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LNK(lnk),
    .START(start), .MODE(mode), .BLANK_DEV(blank_dev),
    .PASSWORD_COUNT_ADDRESS(cnt_adr), .PASSWORD_COMPARE_START(cmp_adr),
    .USR_VALID(usr_valid), .USR_DATA(usr_data),
    .USR_PW(usr_pw), .USR_LAST(usr_last), .USR_READY(usr_ready),
    .CSUM(csum), .CSUM_VALID(csum_valid), .ARG_BAD(arg_bad), .BUSY(busy));
  hrp_dev hrp_dev_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LNK(lnk),
    .MODE(mode), .RX_ERROR(rx_error), .FLASH_ADDR(flash_addr),
    .FLASH_DATA(flash_data), .REC_WR(rec_wr), .REC_ADDR(rec_addr),
    .REC_EXT(rec_ext), .REC_DATA(rec_data), .BLANK(blank),
    .HALTED(halted), .DONE(done));
  hrp_link_asserts hrp_link_asserts_inst (.SYS_CLK(sys_clk),
    .SYS_RST(sys_rst), .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
    .h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid),
    .RX_ERROR(rx_error), .BLANK(blank), .HALTED(halted), .DONE(done));

  assign flash_data = mem[flash_addr];

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    took <= usr_valid && usr_ready;
    if (lnk.d2h_valid) reply_q.push_back(lnk.d2h_data);
    if (csum_valid) csum_seen <= csum;
    if (rec_wr) begin
      wr_count <= wr_count + 1;
      last_adr <= rec_addr;
      last_dat <= rec_data;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rec(input hrp_row_t rw);
    logic [7:0] s;
    logic [7:0] b;
    s = rw.len + rw.adr[15:8] + rw.adr[7:0] + rw.typ;
    strm.push_back(10'h03a);
    strm.push_back({2'b00, rw.len});
    strm.push_back({2'b00, rw.adr[15:8]});
    strm.push_back({2'b00, rw.adr[7:0]});
    strm.push_back({2'b00, rw.typ});
    for (int i = 0; i < int'(rw.len); i++) begin
      b = (i == 0) ? rw.d[15:8] : rw.d[7:0];
      s = s + b;
      strm.push_back({2'b00, b});
    end
    strm.push_back({2'b00, 8'h00 - s + rw.cadj});
  endtask

  task automatic tail(input hrp_row_t rw);
    strm.push_back(10'h05a);
    rec(rw);
    strm.push_back(10'h05a);
    rec(hrp_row_t'{8'h01, 16'h0030, 8'h00, 16'h5500, 8'h00, 1'b0, 16'h0000});
    rec(hrp_row_t'{8'h00, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b0, 16'h0000});
    strm[$] = strm[$] | 10'h100;
  endtask

  task automatic pwd(input logic [15:0] ca, input int n, input int bad,
                     input logic lst);
    for (int i = 0; i < n; i++) begin
      strm.push_back({1'b1, lst && i == n - 1,
        mem[ca + 16'(i)] ^ ((i == bad) ? 8'hff : 8'h00)});
    end
  endtask

  task automatic session(input logic [15:0] na, input logic [15:0] ca,
      input logic bl, input logic [1:0] md, input logic rx,
      input logic hlt, input logic [15:0] sum, input string name);
    int w;
    sys_rst = 1'b1;
    usr_valid = 1'b0;
    repeat (2) tick();
    sys_rst = 1'b0;
    reply_q.delete();
    wr_count = 0;
    csum_seen = 16'h0000;
    mode = md;
    blank_dev = bl;
    cnt_adr = na;
    cmp_adr = ca;
    start = 1'b1;
    tick();
    start = 1'b0;
    foreach (strm[i]) begin
      {usr_pw, usr_last, usr_data} = strm[i];
      usr_valid = 1'b1;
      w = 0;
      do begin
        tick();
        w++;
      end while (!took && w < 200);
      if (!took) break;
    end
    if (took) usr_valid = 1'b0;
    if (rx) begin
      rx_error = 1'b1;
      tick();
      rx_error = 1'b0;
    end
    w = 0;
    while (!done && !halted && w < 300) begin
      tick();
      w++;
    end
    repeat (4) tick();
    check({name, " halted"}, 16'(hlt), 16'(halted));
    check({name, " done"}, 16'(!hlt), 16'(done));
    if (!hlt && md != hrp_pkg::MODE_ERASE) begin
      check({name, " sum"}, sum, csum_seen);
      check({name, " reply"}, sum, {reply_q[0], reply_q[1]});
    end
    check({name, " replies"}, (hlt || md == hrp_pkg::MODE_ERASE) ?
      16'h0000 : 16'h0002, 16'(reply_q.size()));
    check({name, " busy"}, 16'(hlt), 16'(busy));
    $display("end of test %s", name);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {sys_rst, start, blank_dev, usr_valid, usr_pw, usr_last} = 6'h21;
    {rx_error, mode, usr_data, cnt_adr, cmp_adr} = '0;
    {err_count, compares, cycles, wr_count} = '0;
    foreach (mem[i]) mem[i] = 8'hff;
    repeat (4) tick();
    sys_rst = 1'b0;
    tick();
    check("blank after reset", 16'h0001, 16'(blank));
    check("ready after reset", 16'h0001, 16'(lnk.h2d_ready));
    foreach (rows[r]) begin
      strm.delete();
      tail(rows[r]);
      session(16'h1000, 16'h1000, 1'b1, hrp_pkg::MODE_WRITE, 1'b0,
        rows[r].hlt, rows[r].sum, $sformatf("row %0d", r));
      if (!rows[r].hlt) begin
        check("writes", 16'(((rows[r].typ == 8'h00) ? rows[r].len : 8'h00)
          + 8'h01), 16'(wr_count));
        check("write addr", 16'h0030, last_adr);
        check("write data", 16'h0055, 16'(last_dat));
        if (rows[r].typ == 8'h02) check("ext", rows[r].d, rec_ext);
      end
    end
    mem[16'hffff] = 8'h00;
    mem[16'h2000] = 8'h08;
    for (int i = 0; i < 8; i++) mem[16'h3000 + 16'(i)] = 8'(i + 1);
    strm.delete();
    pwd(16'h3000, 8, -1, 1'b0);
    tail(rows[0]);
    session(16'h2000, 16'h3000, 1'b0, hrp_pkg::MODE_RAM, 1'b0, 1'b0,
      16'h01ba, "password ok");
    check("blank flag", 16'h0000, 16'(blank));
    strm.delete();
    pwd(16'h3000, 8, 3, 1'b0);
    session(16'h2000, 16'h3000, 1'b0, hrp_pkg::MODE_WRITE, 1'b0, 1'b1,
      16'h0000, "password wrong");
    mem[16'h3003] = 8'h03;
    mem[16'h3004] = 8'h03;
    strm.delete();
    pwd(16'h3000, 8, -1, 1'b0);
    session(16'h2000, 16'h3000, 1'b0, hrp_pkg::MODE_WRITE, 1'b0, 1'b1,
      16'h0000, "stored run");
    mem[16'h3003] = 8'h04;
    mem[16'h3004] = 8'h05;
    mem[16'h2000] = 8'h07;
    strm.delete();
    pwd(16'h3000, 7, -1, 1'b0);
    session(16'h2000, 16'h3000, 1'b0, hrp_pkg::MODE_WRITE, 1'b0, 1'b1,
      16'h0000, "short count");
    mem[16'h2000] = 8'h08;
    strm.delete();
    pwd(16'hff99, 8, -1, 1'b0);
    session(16'h2000, 16'hff99, 1'b0, hrp_pkg::MODE_WRITE, 1'b0, 1'b1,
      16'h0000, "compare past top");
    strm.delete();
    pwd(16'h3000, 8, -1, 1'b1);
    session(16'h2000, 16'h3000, 1'b0, hrp_pkg::MODE_ERASE, 1'b0, 1'b0,
      16'h0000, "erase");
    mem[16'hffff] = 8'hff;
    strm.delete();
    pwd(16'h3000, 8, -1, 1'b1);
    session(16'h1000, 16'h1000, 1'b1, hrp_pkg::MODE_ERASE, 1'b0, 1'b0,
      16'h0000, "blank erase");
    mem[16'h3000] = 8'h3a;
    strm.delete();
    pwd(16'h3000, 8, -1, 1'b0);
    tail(rows[0]);
    session(16'h1000, 16'h3000, 1'b1, hrp_pkg::MODE_WRITE, 1'b0, 1'b0,
      16'h01ba, "dummy dropped");
    strm.delete();
    strm.push_back(10'h03a);
    session(16'h1000, 16'h1000, 1'b1, hrp_pkg::MODE_WRITE, 1'b1, 1'b1,
      16'h0000, "receive error");
    sys_rst = 1'b1;
    tick();
    sys_rst = 1'b0;
    cnt_adr = 16'h0fff;
    start = 1'b1;
    tick();
    start = 1'b0;
    tick();
    check("count address refused", 16'h0001, 16'(arg_bad));
    $display("end of test argument check");
    stop_test();
  end
endmodule // testbench
